// *** hw/pwm_chan_pkg.sv ***
// Package: register map, field layout and types of the buffered PWM channel block
package pwm_chan_pkg;

  // ----------------------------------------------------------------
  // Geometry
  // ----------------------------------------------------------------
  localparam int unsigned NUM_CHAN  = 4;
  localparam int unsigned NUM_PAIR  = 2;
  localparam int unsigned CMP_W     = 16;
  localparam int unsigned ADDR_W    = 8;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] CTRL_BASE_OFS = 8'h00;  // chan_ctrl_status 0..3, step 4
  localparam logic [ADDR_W-1:0] CTRL_STEP     = 8'h04;
  localparam logic [ADDR_W-1:0] MATCH_BASE_OFS = 8'h10; // chN_match_high, then chN_match_low
  localparam logic [ADDR_W-1:0] MATCH_STEP    = 8'h08;
  localparam logic [ADDR_W-1:0] MATCH_LOW_OFS = 8'h04;

  // ----------------------------------------------------------------
  // Control/status field positions and reset values
  // ----------------------------------------------------------------
  localparam int unsigned FLAG_BIT   = 7;
  localparam logic [7:0]  CTRL_RESET = 8'h00;
  localparam logic [CMP_W-1:0] MATCH_RESET = 16'h0000;
  localparam logic [1:0]  ACT_NONE   = 2'h0;
  localparam logic [1:0]  ACT_TOGGLE = 2'h1;
  localparam logic [1:0]  ACT_CLEAR  = 2'h2;
  localparam logic [1:0]  ACT_SET    = 2'h3;

  // Bit 7 down to bit 0 of a chan_ctrl_status register
  typedef struct packed {
    logic       chan_match_flag;
    logic       chan_irq_enable;
    logic       buffered_mode_select;
    logic       initial_level_select;
    logic [1:0] match_action;          // match_action_hi, match_action_lo
    logic       overflow_toggle_enable;
    logic       force_full_duty;
  } chan_ctrl_type;

  // Captured AHB address phase
  typedef struct packed {
    logic              valid;
    logic              write;
    logic [ADDR_W-1:0] addr;
  } ahb_phase_type;

endpackage : pwm_chan_pkg

// *** hw/pwm_chan_ctrl.sv ***
// Buffered PWM channel control: control registers, compare registers, pin logic, AHB-Lite slave
//
// Behaviour
// - Each channel has a read/write interrupt enable, cleared by reset.
// - Buffered-mode select exists only in channel 0 and channel 2 control.
// - Buffered pair disables odd control register and returns odd pin to GPIO.
// - Buffered select 1 enables, 0 disables buffered operation; reset clears it.
// - With action 00, initial level select 1 presets low, 0 presets high.
// - With action not 00, initial level select has no effect.
// - Action 00 disconnects the channel from its pin.
// - Buffered match action: 01 toggles, 10 drives low, 11 drives high.
// - Reset clears both action bits of every channel.
// - Overflow toggle bit toggles the pin on every counter overflow when action is not 00.
// - With overflow toggle on, overflow beats a compare in same cycle.
// - Full duty forces output high from next period until period after clear.
// - Full duty overrides pin level only; matches still set the flag.
// - Each channel holds a read/write 16-bit compare value in two bytes.
// - High byte write to active buffered channel inhibits matches until low write.
// - Writes to the inactive channel of a pair do not inhibit matches.
// - Unused compare registers remain plain read/write storage.
// - Even channel controls first; last-written channel of the pair takes over at each overflow.
// - Flag sets on match; clears on read-set then write-0, match cancels clear.
// - Compare sets pulse width, modulo sets period, overflow marks period boundary.
//
// Implementation choices: the placing of the registers and register access over AHB-Lite.
`timescale 1ns/1ps

module pwm_chan_ctrl
  import pwm_chan_pkg::*;
#(
  parameter int unsigned CHANNELS = NUM_CHAN
) (
  input  wire logic                core_clk_i,
  input  wire logic                rst_i,
  // AHB-Lite slave
  input  wire logic                hsel_i,
  input  wire logic [ADDR_W-1:0]   haddr_i,
  input  wire logic [1:0]          htrans_i,
  input  wire logic                hwrite_i,
  input  wire logic [2:0]          hsize_i,
  input  wire logic [31:0]         hwdata_i,
  input  wire logic                hready_i,
  output logic                     hreadyout_o,
  output logic                     hresp_o,
  output logic [31:0]              hrdata_o,
  // Modulo counter, same clock
  input  wire logic [CMP_W-1:0]    count_i,
  input  wire logic                count_step_i,
  input  wire logic                count_wrap_i,
  // Channel pins and requests
  output logic [CHANNELS-1:0]      chan_output_pin_o,
  output logic [CHANNELS-1:0]      chan_output_pin_oe_o,
  output logic [CHANNELS-1:0]      chan_irq_o
);

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  chan_ctrl_type           ctrl_r       [CHANNELS];
  logic [CMP_W-1:0]        match_val_r  [CHANNELS];
  logic [CHANNELS-1:0]     inhibit_r;
  logic [CHANNELS-1:0]     clear_armed_r;
  logic [CHANNELS-1:0]     level_r;
  logic [CHANNELS-1:0]     full_duty_r;
  logic [CHANNELS-1:0]     pin_r;
  logic [CHANNELS-1:0]     match;
  logic [CHANNELS/2-1:0]   odd_active_r;
  logic [CHANNELS/2-1:0]   odd_last_r;
  ahb_phase_type           phase_r;
  logic                    rd_wait_r;
  logic [31:0]             hrdata_r;

  // ----------------------------------------------------------------
  // Address decode helpers
  // ----------------------------------------------------------------
  function automatic logic ctrl_hit(input logic [ADDR_W-1:0] a, input int unsigned ch);
    ctrl_hit = (a == CTRL_BASE_OFS + ADDR_W'(ch) * CTRL_STEP);
  endfunction : ctrl_hit

  function automatic logic high_hit(input logic [ADDR_W-1:0] a, input int unsigned ch);
    high_hit = (a == MATCH_BASE_OFS + ADDR_W'(ch) * MATCH_STEP);
  endfunction : high_hit

  function automatic logic low_hit(input logic [ADDR_W-1:0] a, input int unsigned ch);
    low_hit = (a == MATCH_BASE_OFS + ADDR_W'(ch) * MATCH_STEP + MATCH_LOW_OFS);
  endfunction : low_hit

  // Odd channel of a buffered pair is switched off
  function automatic logic chan_off(input int unsigned ch);
    chan_off = (ch % 2 == 1) && ctrl_r[ch-1].buffered_mode_select;
  endfunction : chan_off

  // ----------------------------------------------------------------
  // AHB-Lite slave: writes zero-wait, reads one wait state
  // ----------------------------------------------------------------
  logic accept;
  logic wr_now;
  logic rd_done;

  assign accept      = hsel_i && htrans_i[1] && hready_i;
  assign wr_now      = phase_r.valid && phase_r.write;
  assign rd_done     = rd_wait_r;
  assign hreadyout_o = !(phase_r.valid && !phase_r.write && !rd_wait_r);
  assign hresp_o     = 1'b0;
  assign hrdata_o    = hrdata_r;

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      phase_r <= '0;
    end else if (hreadyout_o) begin
      phase_r <= '{valid: accept, write: hwrite_i, addr: haddr_i};
    end
  end

  // Read data latched in the wait state so it sees last write's result
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      rd_wait_r <= 1'b0;
      hrdata_r  <= 32'h0000_0000;
    end else begin
      rd_wait_r <= phase_r.valid && !phase_r.write && !rd_wait_r;
      if (phase_r.valid && !phase_r.write && !rd_wait_r) begin
        hrdata_r <= 32'h0000_0000;   // unmapped reads as zero
        for (int unsigned c = 0; c < CHANNELS; c++) begin
          if (ctrl_hit(phase_r.addr, c) && !chan_off(c)) begin
            hrdata_r[7:0] <= ctrl_r[c];
          end
          if (high_hit(phase_r.addr, c)) begin
            hrdata_r[7:0] <= match_val_r[c][15:8];
          end
          if (low_hit(phase_r.addr, c)) begin
            hrdata_r[7:0] <= match_val_r[c][7:0];
          end
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      for (int unsigned c = 0; c < CHANNELS; c++) begin
        ctrl_r[c] <= CTRL_RESET;
      end
    end else begin
      for (int unsigned c = 0; c < CHANNELS; c++) begin
        if (wr_now && ctrl_hit(phase_r.addr, c) && !chan_off(c)) begin
          ctrl_r[c].chan_irq_enable        <= hwdata_i[6];
          ctrl_r[c].buffered_mode_select   <= (c % 2 == 0) ? hwdata_i[5] : 1'b0;
          ctrl_r[c].initial_level_select   <= hwdata_i[4];
          ctrl_r[c].match_action           <= hwdata_i[3:2];
          ctrl_r[c].overflow_toggle_enable <= hwdata_i[1];
          ctrl_r[c].force_full_duty        <= hwdata_i[0];
        end
        // Set wins over a pending clear
        if (match[c]) begin
          ctrl_r[c].chan_match_flag <= 1'b1;
        end else if (wr_now && ctrl_hit(phase_r.addr, c) && !chan_off(c)
                     && !hwdata_i[FLAG_BIT] && clear_armed_r[c]) begin
          ctrl_r[c].chan_match_flag <= 1'b0;
        end
      end
    end
  end

  // Clear is armed by reading the flag set; any match disarms it
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      clear_armed_r <= '0;
    end else begin
      for (int unsigned c = 0; c < CHANNELS; c++) begin
        if (match[c]) begin
          clear_armed_r[c] <= 1'b0;
        end else if (rd_done && ctrl_hit(phase_r.addr, c)) begin
          clear_armed_r[c] <= ctrl_r[c].chan_match_flag;
        end else if (wr_now && ctrl_hit(phase_r.addr, c)) begin
          clear_armed_r[c] <= 1'b0;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Compare registers and split-write inhibit
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      for (int unsigned c = 0; c < CHANNELS; c++) begin
        match_val_r[c] <= MATCH_RESET;
      end
    end else begin
      for (int unsigned c = 0; c < CHANNELS; c++) begin
        if (wr_now && high_hit(phase_r.addr, c)) begin
          match_val_r[c][15:8] <= hwdata_i[7:0];
        end
        if (wr_now && low_hit(phase_r.addr, c)) begin
          match_val_r[c][7:0] <= hwdata_i[7:0];
        end
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      inhibit_r <= '0;
    end else begin
      for (int unsigned c = 0; c < CHANNELS; c++) begin
        if (!ctrl_r[c - c % 2].buffered_mode_select || (wr_now && low_hit(phase_r.addr, c))) begin
          inhibit_r[c] <= 1'b0;
        end else if (wr_now && high_hit(phase_r.addr, c)
                     && (odd_active_r[c/2] == c[0])) begin
          inhibit_r[c] <= 1'b1;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Buffered pair hand-over at period boundary
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      odd_last_r   <= '0;
      odd_active_r <= '0;
    end else begin
      for (int unsigned p = 0; p < CHANNELS/2; p++) begin
        if (!ctrl_r[2*p].buffered_mode_select) begin
          odd_last_r[p]   <= 1'b0;
          odd_active_r[p] <= 1'b0;
        end else begin
          if (wr_now && low_hit(phase_r.addr, 2*p + 1)) begin
            odd_last_r[p] <= 1'b1;
          end else if (wr_now && low_hit(phase_r.addr, 2*p)) begin
            odd_last_r[p] <= 1'b0;
          end
          if (count_wrap_i) begin
            odd_active_r[p] <= odd_last_r[p];
          end
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Match detection
  // ----------------------------------------------------------------
  always_comb begin
    for (int unsigned c = 0; c < CHANNELS; c++) begin
      match[c] = 1'b0;
      if (c % 2 == 0 && ctrl_r[c].buffered_mode_select) begin
        if (odd_active_r[c/2]) begin
          match[c] = count_step_i && !inhibit_r[c+1]
                     && (count_i == match_val_r[c+1]);
        end else begin
          match[c] = count_step_i && !inhibit_r[c]
                     && (count_i == match_val_r[c]);
        end
      end else if (!chan_off(c)) begin
        match[c] = count_step_i && (count_i == match_val_r[c]);
      end
    end
  end

  // ----------------------------------------------------------------
  // Output level
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      level_r <= '0;
    end else begin
      for (int unsigned c = 0; c < CHANNELS; c++) begin
        if (ctrl_r[c].match_action == ACT_NONE) begin
          level_r[c] <= !ctrl_r[c].initial_level_select;
        end else if (count_wrap_i && ctrl_r[c].overflow_toggle_enable) begin
          level_r[c] <= !level_r[c];
        end else if (match[c]) begin
          case (ctrl_r[c].match_action)
            ACT_TOGGLE: level_r[c] <= !level_r[c];
            ACT_CLEAR:  level_r[c] <= 1'b0;
            ACT_SET:    level_r[c] <= 1'b1;
            default:    level_r[c] <= level_r[c];
          endcase
        end
      end
    end
  end

  // Full duty follows the bit only at a period boundary
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      full_duty_r <= '0;
    end else begin
      for (int unsigned c = 0; c < CHANNELS; c++) begin
        if (count_wrap_i) begin
          full_duty_r[c] <= ctrl_r[c].force_full_duty;
        end
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      pin_r <= '0;
    end else begin
      for (int unsigned c = 0; c < CHANNELS; c++) begin
        pin_r[c] <= full_duty_r[c] || level_r[c];
      end
    end
  end

  assign chan_output_pin_o = pin_r;

  // Pin enable: disconnected on action 00 or when pair takes odd channel
  always_comb begin
    for (int unsigned c = 0; c < CHANNELS; c++) begin
      chan_output_pin_oe_o[c] = (ctrl_r[c].match_action != ACT_NONE) && !chan_off(c);
      chan_irq_o[c]           = ctrl_r[c].chan_match_flag && ctrl_r[c].chan_irq_enable
                                && !chan_off(c);
    end
  end

endmodule : pwm_chan_ctrl

// *** testbench/pwm_load_model.sv ***
// Partner model: external load on the channel pins
`timescale 1ns/1ps
module pwm_load_model
  import pwm_chan_pkg::*;
(
  input  wire logic [NUM_CHAN-1:0] pin_i,
  input  wire logic [NUM_CHAN-1:0] oe_i,
  output logic      [NUM_CHAN-1:0] line_o
);
  // Released line falls to the pull-down, never keeps the last level
  assign line_o = pin_i & oe_i;
endmodule : pwm_load_model

// *** testbench/pwm_chan_ctrl_chk.sv ***
// Checker: port-level assertions for the PWM channel control block
`timescale 1ns/1ps
module pwm_chan_ctrl_chk
  import pwm_chan_pkg::*;
#(
  parameter int unsigned CHANNELS = NUM_CHAN
) (
  input wire logic                core_clk_i,
  input wire logic                rst_i,
  input wire logic                hsel_i,
  input wire logic [ADDR_W-1:0]   haddr_i,
  input wire logic [1:0]          htrans_i,
  input wire logic                hwrite_i,
  input wire logic [2:0]          hsize_i,
  input wire logic [31:0]         hwdata_i,
  input wire logic                hready_i,
  input wire logic                hreadyout_o,
  input wire logic                hresp_o,
  input wire logic [31:0]         hrdata_o,
  input wire logic [CMP_W-1:0]    count_i,
  input wire logic                count_step_i,
  input wire logic                count_wrap_i,
  input wire logic [CHANNELS-1:0] chan_output_pin_o,
  input wire logic [CHANNELS-1:0] chan_output_pin_oe_o,
  input wire logic [CHANNELS-1:0] chan_irq_o
);
  logic       take;
  logic       wr_dp_r;
  logic [4:0] ev_r;
  assign take = hsel_i & htrans_i[1] & hready_i;
  always_ff @(posedge core_clk_i) begin
    wr_dp_r <= take & hwrite_i;
  end
  // Pin may lag its cause by a few edges, so keep a short history
  always_ff @(posedge core_clk_i) begin
    ev_r <= {ev_r[3:0], count_step_i | count_wrap_i | wr_dp_r | rst_i};
  end
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  reset_quiet_a: assert property ($fell(rst_i) |-> !chan_output_pin_oe_o && !chan_irq_o)
    else $error("pins or requests active after reset");
  read_wait_a: assert property (take && !hwrite_i |=> !hreadyout_o ##1 hreadyout_o)
    else $error("read wait state wrong");
  write_nowait_a: assert property (take && hwrite_i |=> hreadyout_o)
    else $error("write stalled");
  okay_resp_a: assert property (hresp_o == 1'b0)
    else $error("response not okay");
  upper_zero_a: assert property (!hreadyout_o |=> hrdata_o[31:8] == 24'h00_0000)
    else $error("read data upper bits set");
  oe_cause_a: assert property ($changed(chan_output_pin_oe_o) |-> $past(wr_dp_r))
    else $error("pin enable changed without a write");
  irq_cause_a: assert property ($changed(chan_irq_o) |-> $past(count_step_i) || $past(wr_dp_r))
    else $error("request changed without match or write");
  pin_cause_a: assert property ($changed(chan_output_pin_o) |-> |ev_r)
    else $error("pin changed without a cause");
endmodule : pwm_chan_ctrl_chk

// *** testbench/buffered_pwm_channel_control_test.sv ***
// Testbench: registers, matches and pin behaviour of the PWM channel control block
`timescale 1ns/1ps
module buffered_pwm_channel_control_test;
  import pwm_chan_pkg::*;
  logic        core_clk_i = 1'b0;
  logic        rst_i      = 1'b1;
  logic        hsel_i     = 1'b0;
  logic [7:0]  haddr_i    = 8'h00;
  logic [1:0]  htrans_i   = 2'b00;
  logic        hwrite_i   = 1'b0;
  logic [2:0]  hsize_i    = 3'b010;
  logic [31:0] hwdata_i   = 32'h0000_0000;
  logic [15:0] count_i    = 16'h0000;
  logic        count_step_i = 1'b0;
  logic        count_wrap_i = 1'b0;
  wire  logic  hready_i;
  logic        hreadyout_o;
  logic        hresp_o;
  logic [31:0] hrdata_o;
  logic [3:0]  chan_output_pin_o;
  logic [3:0]  chan_output_pin_oe_o;
  logic [3:0]  chan_irq_o;
  logic [3:0]  line;
  int          error_cnt   = 0;
  int          comparisons = 0;
  int          cyc         = 0;
  logic [31:0] rd;
  logic [7:0]  m_cmp [8];
  assign hready_i = hreadyout_o;
  always #5 core_clk_i = ~core_clk_i;
  pwm_chan_ctrl u_dut (.core_clk_i, .rst_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i, .hsize_i,
    .hwdata_i, .hready_i, .hreadyout_o, .hresp_o, .hrdata_o, .count_i, .count_step_i,
    .count_wrap_i, .chan_output_pin_o, .chan_output_pin_oe_o, .chan_irq_o);
  pwm_load_model u_load (.pin_i(chan_output_pin_o), .oe_i(chan_output_pin_oe_o), .line_o(line));
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : wrap_up
  always @(posedge core_clk_i) begin
    cyc++;
    if (cyc > 20000) begin
      error_cnt++;
      wrap_up();
    end
  end
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic chk_pin(input string what, input logic exp);
    // Let control, level and pin flops settle before looking at the line
    repeat (3) @(posedge core_clk_i);
    comparisons++;
    if (line[2] !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %b seen %b", what, exp, line[2]);
    end
  endtask : chk_pin
  // One single word transfer; read data taken at the completing edge
  task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] wd);
    hsel_i   <= 1'b1;
    htrans_i <= 2'b10;
    hwrite_i <= wr;
    haddr_i  <= a;
    do @(posedge core_clk_i); while (hreadyout_o !== 1'b1);
    hsel_i   <= 1'b0;
    htrans_i <= 2'b00;
    hwdata_i <= {24'h00_0000, wd};
    do @(posedge core_clk_i); while (hreadyout_o !== 1'b1);
    rd = hrdata_o;
  endtask : bus
  task automatic rd_chk(input string what, input logic [7:0] a, input logic [7:0] exp);
    bus(1'b0, a, 8'h00);
    chk(what, {24'h00_0000, exp}, rd);
  endtask : rd_chk
  // Counter sweep, one step per value
  task automatic count(input int lo, input int hi);
    for (int v = lo; v <= hi; v++) begin
      count_i      <= v[15:0];
      count_step_i <= 1'b1;
      @(posedge core_clk_i);
    end
    count_step_i <= 1'b0;
    repeat (3) @(posedge core_clk_i);
  endtask : count
  task automatic wrap(input logic stp);
    count_i      <= 16'h0005;
    count_step_i <= stp;
    count_wrap_i <= 1'b1;
    @(posedge core_clk_i);
    count_step_i <= 1'b0;
    count_wrap_i <= 1'b0;
    repeat (3) @(posedge core_clk_i);
  endtask : wrap
  // Set the control, sweep, check the flag, then write back to clear it
  task automatic probe(input int ch, input int lo, input int hi, input logic f, input logic [7:0] c);
    bus(1'b1, 8'(ch * 4), c);
    count(lo, hi);
    rd_chk("ctrl flag", 8'(ch * 4), {f, c[6:0]});
    bus(1'b1, 8'(ch * 4), c);
  endtask : probe
  initial begin
    void'($urandom(17));
    repeat (6) @(posedge core_clk_i);
    rst_i <= 1'b0;
    @(posedge core_clk_i);
    for (int n = 0; n < 4; n++) rd_chk("ctrl reset", 8'(n * 4), 8'h00);
    chk("lines idle", 32'h0, {28'h0, line});
    $display("reset test done");
    // Timer held still (no steps, no wraps) around mode writes
    for (int i = 0; i < 8; i++) begin
      m_cmp[i] = 8'($urandom_range(255));
      bus(1'b1, 8'(16 + 4 * i), m_cmp[i]);
    end
    for (int i = 0; i < 8; i++) rd_chk("compare byte", 8'(16 + 4 * i), m_cmp[i]);
    bus(1'b1, 8'hF0, 8'h5A);
    rd_chk("unmapped", 8'hF0, 8'h00);
    bus(1'b1, 8'h04, 8'h7F);
    rd_chk("odd ctrl", 8'h04, 8'h5F);
    bus(1'b1, 8'h04, 8'h00);
    bus(1'b1, 8'h00, 8'h20);
    bus(1'b1, 8'h04, 8'h0C);
    rd_chk("odd ctrl disabled", 8'h04, 8'h00);
    chk("odd pin released", 32'h0, {31'h0, chan_output_pin_oe_o[1]});
    $display("register test done");
    bus(1'b1, 8'h20, 8'h00);
    bus(1'b1, 8'h24, 8'h05);
    bus(1'b1, 8'h08, 8'h10);
    bus(1'b1, 8'h08, 8'h1C);
    chk_pin("preset low", 1'b0);
    bus(1'b1, 8'h08, 8'h00);
    bus(1'b1, 8'h08, 8'h4C);
    chk_pin("preset high", 1'b1);
    for (int a = 3; a > 0; a--) begin
      probe(2, 0, 8, 1'b1, 8'(8'h40 | (a << 2)));
      chk_pin("match action", a != 2);
    end
    probe(2, 0, 8, 1'b1, 8'h44);
    rd_chk("flag cleared", 8'h08, 8'h44);
    count(0, 8);
    chk("request", 32'h1, {31'h0, chan_irq_o[2]});
    bus(1'b0, 8'h08, 8'h00);
    count(4, 6);
    bus(1'b1, 8'h08, 8'h44);
    rd_chk("clear cancelled", 8'h08, 8'hC4);
    chk_pin("toggled twice", 1'b0);
    $display("match test done");
    bus(1'b1, 8'h08, 8'h46);
    wrap(1'b0);
    chk_pin("overflow toggle", 1'b1);
    bus(1'b1, 8'h08, 8'h4E);
    count(0, 8);
    wrap(1'b1);
    chk_pin("overflow first", 1'b0);
    bus(1'b1, 8'h08, 8'h49);
    chk_pin("full duty waits", 1'b0);
    wrap(1'b0);
    probe(2, 0, 8, 1'b1, 8'h49);
    chk_pin("full duty", 1'b1);
    bus(1'b1, 8'h08, 8'h48);
    chk_pin("full duty held", 1'b1);
    wrap(1'b0);
    chk_pin("full duty released", 1'b0);
    $display("overflow test done");
    bus(1'b1, 8'h10, 8'h00);
    bus(1'b1, 8'h14, 8'h03);
    bus(1'b1, 8'h00, 8'h2C);
    probe(0, 0, 5, 1'b1, 8'h2C);
    bus(1'b1, 8'h18, 8'h00);
    bus(1'b1, 8'h1C, 8'h07);
    probe(0, 0, 5, 1'b1, 8'h2C);
    wrap(1'b0);
    probe(0, 0, 5, 1'b0, 8'h2C);
    probe(0, 6, 8, 1'b1, 8'h2C);
    bus(1'b1, 8'h18, 8'h00);
    probe(0, 6, 8, 1'b0, 8'h2C);
    bus(1'b1, 8'h1C, 8'h07);
    probe(0, 6, 8, 1'b1, 8'h2C);
    $display("buffered test done");
    wrap_up();
  end
endmodule : buffered_pwm_channel_control_test
bind pwm_chan_ctrl pwm_chan_ctrl_chk #(.CHANNELS(CHANNELS)) u_chk (.core_clk_i, .rst_i, .hsel_i,
  .haddr_i, .htrans_i, .hwrite_i, .hsize_i, .hwdata_i, .hready_i, .hreadyout_o, .hresp_o,
  .hrdata_o, .count_i, .count_step_i, .count_wrap_i, .chan_output_pin_o,
  .chan_output_pin_oe_o, .chan_irq_o);
